// file: rtl/lbs_pkg.sv
// Contract
// R1 - Blinking dots complete one on/off cycle in about 1.6 s at 80 Hz frames.
// R2 - Blinking is limited to lines from blink_first_line through blink_last_line.
// R3 - Each mask bit covers 5 dot columns in character mode, 8 in graphic.
// R4 - Only dot groups whose blink_column_mask bit is 1 blink; others display normally.
// R5 - Software programs area then sets blink_enable; blinking runs only while it is 1.
// R6 - Blink area matches memory line addresses, so it scrolls with the content.
// R7 - Module standby stops boost and op-amps, drives commons and segments to ground.
// R8 - Standby keeps all registers except the display-on and opamp_enable bits.
// R9 - Control registers stay readable and writable during module standby.
// R10 - Software sets cpu_standby_prep before CPU standby, then runs release sequence.
// R11 - On standby entry drive power turns off within two subclock cycles.
// R12 - The step-up converter runs only while boost_enable is 1.
// R13 - The converter is clocked by the subclock; no subclock means no boosting.
// R14 - The V1 to V5 op-amps are powered only while opamp_enable is 1.
// R15 - For external V1 to V5 software clears boost_enable and opamp_enable.
// R16 - Commons use V1, V2, V5 or ground; segments use V1, V3, V4 or ground.
// R17 - The drive voltage follows the value written into contrast_level.
// R18 - display_mode_select 0 gives 5-bit character mode, 1 gives 8-bit graphic mode.
// R19 - A frame counter inverts the blink state every 64 frames, 128 per cycle.
// R20 - Blanked-phase blinking dots output dark; memory contents stay untouched.
`default_nettype none
package lbs_pkg;
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_MASK = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_FIRST = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_LAST = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_CONTRAST = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h6;
  // control_reg_one fields
  localparam int B1_BOOST = 0;
  localparam int B1_PREP = 1;
  localparam int B1_SBY = 2;
  localparam int B1_MODE = 3;
  // control_reg_two fields
  localparam int B2_DISP = 0;
  localparam int B2_OPAMP = 1;
  localparam int B2_BLINK = 2;
  // status fields
  localparam int BS_PHASE = 0;
  localparam int BS_BOOST = 1;
  localparam int BS_OPAMP = 2;
  localparam int BS_SBY = 3;
  localparam int LINE_W = 5;
  localparam int COL_W = 3;
  localparam int DOT_W = 8;
  localparam int CC_W = 4;
  localparam logic [DOT_W-1:0] CHAR_DOTS = 8'h1F;
  localparam logic [CC_W-1:0] CONTRAST_RST = 4'h0;
  localparam logic [LINE_W-1:0] LINE_RST = 5'h00;
  localparam logic [DOT_W-1:0] MASK_RST = 8'h00;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
  // Blink timing
  localparam int FRAME_HZ = 80;
  localparam int BLINK_PERIOD_MS = 1600;
  localparam int BLINK_FRAMES = FRAME_HZ * BLINK_PERIOD_MS / 1000;
  localparam int BLINK_HALF = BLINK_FRAMES / 2;
  typedef struct packed {
    logic [LINE_W-1:0] line;
    logic [COL_W-1:0] col;
    logic [DOT_W-1:0] dots;
  } lbs_pix_type;
  typedef enum logic [1:0] {
    COM_GND = 2'h0, COM_V1 = 2'h1, COM_V2 = 2'h2, COM_V5 = 2'h3
  } lbs_com_type;
  typedef enum logic [1:0] {
    SEG_GND = 2'h0, SEG_V1 = 2'h1, SEG_V3 = 2'h2, SEG_V4 = 2'h3
  } lbs_seg_type;
  typedef enum logic {SBY_RUN = 1'b0, SBY_IDLE = 1'b1} lbs_sby_type;
endpackage : lbs_pkg
`default_nettype wire

// file: rtl/lbs_sync.sv
`default_nettype none
module lbs_sync import lbs_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : lbs_sync
`default_nettype wire

// file: rtl/lbs_blink_timer.sv
`default_nettype none
module lbs_blink_timer import lbs_pkg::*; #(
  parameter int HALF_FRAMES = BLINK_HALF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic enable,
  input wire logic frame_start,
  // Phase, 1 while blanked
  output logic phase_q
);
  localparam int CW = $clog2(HALF_FRAMES);
  localparam logic [CW-1:0] LAST = CW'(HALF_FRAMES - 1);
  logic [CW-1:0] frame_cnt_q;
  // Restart shown so blinking always opens visible
  always_ff @(posedge clk_sys) begin
    if (reset || !enable) begin
      frame_cnt_q <= '0;
      phase_q <= 1'b0;
    end else if (frame_start) begin
      if (frame_cnt_q == LAST) begin // [R19] [R1]
        frame_cnt_q <= '0;
        phase_q <= !phase_q;
      end else begin
        frame_cnt_q <= frame_cnt_q + 1'b1;
      end
    end
  end
  property p_phase_on_frame;
    @(posedge clk_sys) disable iff (reset)
      enable && $changed(phase_q) |-> $past(frame_start) && $past(frame_cnt_q) == LAST;
  endproperty
  a_phase_on_frame: assert property (p_phase_on_frame) // [R19]
    else $error("Blink phase flipped off the frame boundary");
endmodule : lbs_blink_timer
`default_nettype wire

// file: rtl/lbs_ctrl.sv
`default_nettype none
module lbs_ctrl import lbs_pkg::*; #(
  parameter int HALF_FRAMES = BLINK_HALF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Asynchronous pins
  input wire logic sub_clk,
  input wire logic cpu_standby_req,
  // Display read stream
  input wire logic frame_start,
  input wire logic pix_in_valid,
  input wire lbs_pix_type pix_in,
  output logic pix_out_valid,
  output logic [DOT_W-1:0] pix_out_dots,
  // Drive level selection
  input wire lbs_com_type com_sel,
  input wire lbs_seg_type seg_sel,
  output lbs_com_type com_level,
  output lbs_seg_type seg_level,
  // Power control
  output logic boost_run,
  output logic boost_clk,
  output logic opamp_on,
  output logic [CC_W-1:0] contrast_out,
  output logic display_mode
);
  logic boost_en_q, prep_q, sby_bit_q, mode_q;
  logic disp_on_q, opamp_en_q, blink_en_q;
  logic [DOT_W-1:0] mask_q;
  logic [LINE_W-1:0] first_q, last_q;
  logic [CC_W-1:0] contrast_q;
  lbs_sby_type sby_q;
  logic sby_d, sby_enter;
  logic sub_s, sub_prev_q, cpu_sby_s;
  logic phase;
  logic req, wr_take, rd_take, hit;

  lbs_sync #(.W(2)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({sub_clk, cpu_standby_req}),
    .sync_out({sub_s, cpu_sby_s})
  );

  lbs_blink_timer #(.HALF_FRAMES(HALF_FRAMES)) u_blink (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(blink_en_q), // [R5]
    .frame_start(frame_start),
    .phase_q(phase)
  );

  function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    sel = (a == o);
  endfunction : sel

  // One wait cycle per access, standby or not
  assign req = avs_read || avs_write;
  assign wr_take = avs_write && !avs_waitrequest;
  assign rd_take = avs_read && !avs_waitrequest;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest); // [R9]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_readdata <= BUS_ZERO;
    end else if (req && avs_waitrequest) begin
      avs_readdata <= BUS_ZERO;
      unique case (1'b1)
        sel(avs_address, OFS_CTRL_ONE): begin
          avs_readdata[B1_BOOST] <= boost_en_q;
          avs_readdata[B1_PREP] <= prep_q;
          avs_readdata[B1_SBY] <= sby_bit_q;
          avs_readdata[B1_MODE] <= mode_q;
        end
        sel(avs_address, OFS_CTRL_TWO): begin
          avs_readdata[B2_DISP] <= disp_on_q;
          avs_readdata[B2_OPAMP] <= opamp_en_q;
          avs_readdata[B2_BLINK] <= blink_en_q;
        end
        sel(avs_address, OFS_MASK): avs_readdata[DOT_W-1:0] <= mask_q;
        sel(avs_address, OFS_FIRST): avs_readdata[LINE_W-1:0] <= first_q;
        sel(avs_address, OFS_LAST): avs_readdata[LINE_W-1:0] <= last_q;
        sel(avs_address, OFS_CONTRAST): avs_readdata[CC_W-1:0] <= contrast_q;
        sel(avs_address, OFS_STATUS): begin
          avs_readdata[BS_PHASE] <= phase;
          avs_readdata[BS_BOOST] <= boost_run;
          avs_readdata[BS_OPAMP] <= opamp_on;
          avs_readdata[BS_SBY] <= sby_q;
        end
        default: avs_readdata <= BUS_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      boost_en_q <= 1'b0;
      prep_q <= 1'b0;
      sby_bit_q <= 1'b0;
      mode_q <= 1'b0;
    end else if (wr_take && sel(avs_address, OFS_CTRL_ONE)) begin
      boost_en_q <= avs_writedata[B1_BOOST];
      prep_q <= avs_writedata[B1_PREP]; // [R10]
      sby_bit_q <= avs_writedata[B1_SBY];
      mode_q <= avs_writedata[B1_MODE];
    end
  end

  // Standby entry wins over a same-cycle write to these two bits
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      disp_on_q <= 1'b0;
      opamp_en_q <= 1'b0;
      blink_en_q <= 1'b0;
    end else begin
      if (wr_take && sel(avs_address, OFS_CTRL_TWO)) begin
        disp_on_q <= avs_writedata[B2_DISP];
        opamp_en_q <= avs_writedata[B2_OPAMP];
        blink_en_q <= avs_writedata[B2_BLINK]; // [R5]
      end
      if (sby_enter) begin
        disp_on_q <= 1'b0; // [R8]
        opamp_en_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mask_q <= MASK_RST;
      first_q <= LINE_RST;
      last_q <= LINE_RST;
      contrast_q <= CONTRAST_RST;
    end else if (wr_take) begin
      if (sel(avs_address, OFS_MASK)) mask_q <= avs_writedata[DOT_W-1:0];
      if (sel(avs_address, OFS_FIRST)) first_q <= avs_writedata[LINE_W-1:0];
      if (sel(avs_address, OFS_LAST)) last_q <= avs_writedata[LINE_W-1:0];
      if (sel(avs_address, OFS_CONTRAST)) contrast_q <= avs_writedata[CC_W-1:0]; // [R17]
    end
  end

  // CPU standby only counts once software has armed the prep bit
  assign sby_d = sby_bit_q || (prep_q && cpu_sby_s); // [R10]
  assign sby_enter = sby_d && (sby_q == SBY_RUN);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sby_q <= SBY_RUN;
    end else begin
      unique case (sby_q)
        SBY_RUN: if (sby_d) sby_q <= SBY_IDLE;
        SBY_IDLE: if (!sby_d) sby_q <= SBY_RUN;
      endcase
    end
  end

  // Power cut one system clock after entry, far inside two subclocks
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      boost_run <= 1'b0;
      opamp_on <= 1'b0;
      sub_prev_q <= 1'b0;
      boost_clk <= 1'b0;
    end else begin
      boost_run <= boost_en_q && !sby_d; // [R12] [R11] [R7]
      opamp_on <= opamp_en_q && !sby_d; // [R14] [R7]
      sub_prev_q <= sub_s;
      if (!boost_run) begin
        boost_clk <= 1'b0;
      end else if (sub_s && !sub_prev_q) begin
        boost_clk <= !boost_clk; // [R13]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      contrast_out <= CONTRAST_RST;
      display_mode <= 1'b0;
      com_level <= COM_GND;
      seg_level <= SEG_GND;
    end else begin
      contrast_out <= contrast_q; // [R17]
      display_mode <= mode_q; // [R18]
      com_level <= (sby_d || !disp_on_q) ? COM_GND : com_sel; // [R16] [R7]
      seg_level <= (sby_d || !disp_on_q) ? SEG_GND : seg_sel; // [R16] [R7]
    end
  end

  // Line match on memory address, so scrolling carries the area along
  assign hit = blink_en_q && phase && pix_in.line >= first_q
    && pix_in.line <= last_q && mask_q[pix_in.col]; // [R2] [R4] [R6] [R3]

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pix_out_valid <= 1'b0;
      pix_out_dots <= '0;
    end else begin
      pix_out_valid <= pix_in_valid;
      if (hit) begin
        pix_out_dots <= '0; // [R20]
      end else begin
        pix_out_dots <= mode_q ? pix_in.dots : (pix_in.dots & CHAR_DOTS); // [R18] [R3]
      end
    end
  end

  sequence s_req_seen;
    req && avs_waitrequest;
  endsequence
  sequence s_answered;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_bus_answer;
    @(posedge clk_sys) disable iff (reset) s_req_seen |=> s_answered;
  endproperty
  a_bus_answer: assert property (p_bus_answer) // [R9]
    else $error("Register access not answered in one cycle");

  property p_standby_blank;
    @(posedge clk_sys) disable iff (reset)
      sby_q == SBY_IDLE |-> com_level == COM_GND && seg_level == SEG_GND;
  endproperty
  a_standby_blank: assert property (p_standby_blank) // [R7]
    else $error("Drive levels not grounded in standby");

  property p_standby_power;
    @(posedge clk_sys) disable iff (reset) sby_enter |=> !boost_run && !opamp_on;
  endproperty
  a_standby_power: assert property (p_standby_power) // [R11]
    else $error("Drive power still on after standby entry");

  property p_standby_loses;
    @(posedge clk_sys) disable iff (reset) sby_enter |=> !disp_on_q && !opamp_en_q;
  endproperty
  a_standby_loses: assert property (p_standby_loses) // [R8]
    else $error("Display-on or op-amp bit retained across standby");

  property p_boost_gate;
    @(posedge clk_sys) disable iff (reset) !boost_en_q |=> !boost_run ##1 !boost_clk;
  endproperty
  a_boost_gate: assert property (p_boost_gate) // [R12]
    else $error("Converter running with boost disabled");

  property p_boost_sub;
    @(posedge clk_sys) disable iff (reset)
      $past(boost_run) && $changed(boost_clk) |-> $past(sub_s) && !$past(sub_prev_q);
  endproperty
  a_boost_sub: assert property (p_boost_sub) // [R13]
    else $error("Converter clock moved without a subclock edge");

  property p_opamp_gate;
    @(posedge clk_sys) disable iff (reset) opamp_on |-> $past(opamp_en_q);
  endproperty
  a_opamp_gate: assert property (p_opamp_gate) // [R14]
    else $error("Op-amps powered without enable");

  property p_blank_dots;
    @(posedge clk_sys) disable iff (reset) hit |=> pix_out_dots == '0;
  endproperty
  a_blank_dots: assert property (p_blank_dots) // [R20]
    else $error("Blinking dots lit in blanked phase");

  property p_normal_dots;
    @(posedge clk_sys) disable iff (reset)
      !blink_en_q && mode_q |=> pix_out_dots == $past(pix_in.dots);
  endproperty
  a_normal_dots: assert property (p_normal_dots) // [R4]
    else $error("Dots altered with blinking off");

  property p_char_width;
    @(posedge clk_sys) disable iff (reset) !mode_q |=> (pix_out_dots & ~CHAR_DOTS) == '0;
  endproperty
  a_char_width: assert property (p_char_width) // [R18]
    else $error("Character mode output more than five dots");
endmodule : lbs_ctrl
`default_nettype wire

// file: verif/lbs_panel.sv
`default_nettype none
module lbs_panel import lbs_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Electrode levels
  input wire lbs_com_type com_level,
  input wire lbs_seg_type seg_level,
  // Observation
  output logic blank_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // Dark only while both electrodes sit at ground
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      blank_q <= 1'b1;
    end else begin
      blank_q <= (com_level == COM_GND) && (seg_level == SEG_GND);
    end
  end
endmodule : lbs_panel
`default_nettype wire

// file: verif/lcd_blink_standby_power_ctrl_test.sv
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module lcd_blink_standby_power_ctrl_test import lbs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset, avs_read, avs_write, avs_waitrequest, sub_clk, cpu_standby_req;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic frame_start, pix_in_valid, pix_out_valid, boost_run, boost_clk, opamp_on;
  logic display_mode, panel_blank, sub_en, bclk_d;
  logic [DOT_W-1:0] pix_out_dots;
  logic [CC_W-1:0] contrast_out;
  logic [2:0] sub_div;
  lbs_pix_type pix_in;
  lbs_com_type com_sel, com_level;
  lbs_seg_type seg_sel, seg_level;
  int failures, compares, tog_n, t0;

  lbs_ctrl #(.HALF_FRAMES(2)) i_dut (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sub_clk(sub_clk),
    .cpu_standby_req(cpu_standby_req), .frame_start(frame_start),
    .pix_in_valid(pix_in_valid), .pix_in(pix_in), .pix_out_valid(pix_out_valid),
    .pix_out_dots(pix_out_dots), .com_sel(com_sel), .seg_sel(seg_sel),
    .com_level(com_level), .seg_level(seg_level), .boost_run(boost_run),
    .boost_clk(boost_clk), .opamp_on(opamp_on), .contrast_out(contrast_out),
    .display_mode(display_mode));
  lbs_panel i_panel (.clk_sys(clk_sys), .reset(reset), .com_level(com_level),
    .seg_level(seg_level), .blank_q(panel_blank));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Slow subclock, gated so its absence can be shown
  always @(posedge clk_sys) begin
    sub_div <= sub_div + 3'h1;
    if (sub_en && sub_div == 3'h7) sub_clk <= ~sub_clk;
    bclk_d <= boost_clk;
    if (bclk_d !== boost_clk) tog_n <= tog_n + 1;
  end

  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      tally_and_finish();
    end
  endtask : bus
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, BUS_ZERO, x);
    `CHK("readdata", e, x)
  endtask : rdc
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      frame_start <= 1'b1;
      @(posedge clk_sys);
      frame_start <= 1'b0;
    end
    cyc(3);
  endtask : frames
  task automatic pix(input logic [4:0] l, input logic [2:0] c, input logic [7:0] d,
                     input logic [7:0] e);
    @(posedge clk_sys);
    pix_in <= '{line: l, col: c, dots: d};
    pix_in_valid <= 1'b1;
    @(posedge clk_sys);
    pix_in_valid <= 1'b0;
    #1;
    `CHK("pix_out_valid", 1'b1, pix_out_valid)
    `CHK("pix_out_dots", e, pix_out_dots)
  endtask : pix
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done

  initial begin
    {reset, avs_read, avs_write, sub_clk, cpu_standby_req, frame_start} = 6'h20;
    {pix_in_valid, sub_en, bclk_d, sub_div, avs_address} = '0;
    {avs_writedata, pix_in, failures, compares, tog_n} = '0;
    com_sel = COM_GND;
    seg_sel = SEG_GND;
    cyc(4);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rdc(ADDR_W'(i), BUS_ZERO);
    wr(3'h7, 32'hFFFF_FFFF);
    rdc(3'h7, BUS_ZERO);
    wr(OFS_STATUS, 32'h0000_000F);
    rdc(OFS_STATUS, BUS_ZERO);
    done("registers");
    wr(OFS_CTRL_ONE, 32'h1);
    cyc(4);
    `CHK("boost_run", 1'b1, boost_run)
    sub_en <= 1'b1;
    t0 = tog_n;
    cyc(64);
    `CHK("boost_clk runs", 1'b1, tog_n != t0)
    sub_en <= 1'b0;
    cyc(8);
    t0 = tog_n;
    cyc(64);
    `CHK("boost_clk still", 1'b1, tog_n == t0)
    wr(OFS_CTRL_TWO, 32'h2);
    cyc(4);
    `CHK("opamp_on", 1'b1, opamp_on)
    wr(OFS_CONTRAST, 32'h9);
    cyc(3);
    `CHK("contrast_out", 4'h9, contrast_out)
    wr(OFS_CTRL_ONE, BUS_ZERO);
    wr(OFS_CTRL_TWO, BUS_ZERO);
    cyc(4);
    `CHK("boost_run off", 1'b0, boost_run)
    `CHK("opamp_on off", 1'b0, opamp_on)
    done("power");
    wr(OFS_CTRL_TWO, 32'h1);
    for (int i = 0; i < 4; i++) begin
      com_sel <= lbs_com_type'(i);
      seg_sel <= lbs_seg_type'(3 - i);
      cyc(4);
      `CHK("com_level", lbs_com_type'(i), com_level)
      `CHK("seg_level", lbs_seg_type'(3 - i), seg_level)
      `CHK("panel_blank", 1'b0, panel_blank)
    end
    done("levels");
    wr(OFS_MASK, 32'h2);
    wr(OFS_FIRST, 32'h3);
    wr(OFS_LAST, 32'h5);
    wr(OFS_CTRL_ONE, 32'h8);
    // Mode bit lands at the accepting edge, the pin one edge later
    cyc(2);
    `CHK("display_mode", 1'b1, display_mode)
    frames(2);
    rdc(OFS_STATUS, BUS_ZERO);
    wr(OFS_CTRL_TWO, 32'h5);
    frames(2);
    rdc(OFS_STATUS, 32'h1);
    frames(2);
    rdc(OFS_STATUS, BUS_ZERO);
    pix(5'h04, 3'h1, 8'hA5, 8'hA5);
    frames(2);
    pix(5'h04, 3'h1, 8'hA5, 8'h00);
    pix(5'h03, 3'h1, 8'hA5, 8'h00);
    pix(5'h05, 3'h1, 8'hA5, 8'h00);
    pix(5'h06, 3'h1, 8'hA5, 8'hA5);
    pix(5'h02, 3'h1, 8'hA5, 8'hA5);
    pix(5'h04, 3'h0, 8'hA5, 8'hA5);
    pix(5'h04, 3'h2, 8'hA5, 8'hA5);
    wr(OFS_CTRL_ONE, BUS_ZERO);
    pix(5'h04, 3'h1, 8'hFF, 8'h00);
    pix(5'h04, 3'h0, 8'hFF, 8'h1F);
    wr(OFS_CTRL_TWO, 32'h1);
    cyc(2);
    rdc(OFS_STATUS, BUS_ZERO);
    pix(5'h04, 3'h1, 8'hFF, 8'h1F);
    done("blink");
    wr(OFS_CTRL_TWO, 32'h7);
    com_sel <= COM_V1;
    wr(OFS_CTRL_ONE, 32'h5);
    cyc(4);
    `CHK("com_level sby", COM_GND, com_level)
    `CHK("seg_level sby", SEG_GND, seg_level)
    `CHK("boost_run sby", 1'b0, boost_run)
    `CHK("opamp_on sby", 1'b0, opamp_on)
    `CHK("panel_blank sby", 1'b1, panel_blank)
    rdc(OFS_CTRL_TWO, 32'h4);
    rdc(OFS_MASK, 32'h2);
    wr(OFS_CONTRAST, 32'h3);
    rdc(OFS_CONTRAST, 32'h3);
    rdc(OFS_STATUS, 32'h8);
    wr(OFS_CTRL_ONE, 32'h3);
    cyc(4);
    `CHK("boost_run prep", 1'b1, boost_run)
    cpu_standby_req <= 1'b1;
    cyc(6);
    `CHK("boost_run cpu sby", 1'b0, boost_run)
    rdc(OFS_STATUS, 32'h8);
    cpu_standby_req <= 1'b0;
    cyc(4);
    wr(OFS_CTRL_TWO, 32'h3);
    cyc(4);
    `CHK("opamp_on back", 1'b1, opamp_on)
    `CHK("boost_run back", 1'b1, boost_run)
    done("standby");
    tally_and_finish();
  end
endmodule : lcd_blink_standby_power_ctrl_test
`default_nettype wire
